// ### cid_regs.svh
// Constants of the caller identification message framer
`ifndef CID_REGS_SVH
`define CID_REGS_SVH

`define CID_MCLK_HZ          125000000
`define CID_LINE_BAUD        1200
`define CID_BIT_CYCLES       (`CID_MCLK_HZ / `CID_LINE_BAUD)
`define CID_CNT_W            17
`define CID_MARK_MIN_BITS    4'hA
`define CID_SEIZE_MIN_WORDS  4'h8
`define CID_SEIZE_WORD       8'h55
`define CID_MULTI_TYPE       8'h80
`define CID_SINGLE_TYPE      8'h04
`define CID_START_LEVEL      1'b0
`define CID_STOP_LEVEL       1'b1
`define CID_LINE_IDLE        3'h7
`define CID_PIN_RESET        3'h0
`define CID_MEM_AW           9
`define CID_MEM_DEPTH        512
`define CID_LAST_BIT_IDX     3'h7

`endif

// ### cid_pkg.sv
// Types shared by the caller identification framer and its helpers
package cid_pkg;

  typedef enum logic [3:0] {
    RX_IDLE  = 4'b0001,
    RX_START = 4'b0010,
    RX_DATA  = 4'b0100,
    RX_STOP  = 4'b1000
  } rxState_t;

  typedef enum logic [10:0] {
    P_LEAD    = 11'b000_0000_0001,
    P_MTYPE   = 11'b000_0000_0010,
    P_MLEN    = 11'b000_0000_0100,
    P_PTYPE   = 11'b000_0000_1000,
    P_PLEN    = 11'b000_0001_0000,
    P_PDATA   = 11'b000_0010_0000,
    P_CSUM    = 11'b000_0100_0000,
    P_RDADDR  = 11'b000_1000_0000,
    P_RDWAIT  = 11'b001_0000_0000,
    P_PUSH    = 11'b010_0000_0000,
    P_STANDBY = 11'b100_0000_0000
  } parseState_t;

  typedef enum logic [2:0] {
    K_MTYPE = 3'h0,
    K_MLEN  = 3'h1,
    K_PTYPE = 3'h2,
    K_PLEN  = 3'h3,
    K_DATA  = 3'h4
  } wordKind_t;

  typedef struct packed {
    wordKind_t  kind;
    logic [7:0] data;
  } memWord_t;

  typedef struct packed {
    logic       toStore;
    logic       lastWord;
    wordKind_t  kind;
    logic [7:0] data;
  } outWord_t;

  typedef struct packed {
    outWord_t e0;
    outWord_t e1;
    logic     v0;
    logic     v1;
  } bufState_t;

  typedef struct packed {
    logic [2:0]  lineSync;
    logic        lineLvl;
    logic [2:0]  hookSync;
    logic        onHookLvl;
    logic [2:0]  ansSync;
    logic        ansLvl;
    rxState_t    rx;
    logic [16:0] bitCnt;
    logic [2:0]  bitIdx;
    logic [7:0]  shift;
    logic [3:0]  markCnt;
    parseState_t ps;
    logic [3:0]  seizeCnt;
    logic        multi;
    logic [7:0]  remain;
    logic [7:0]  plen;
    logic [7:0]  sum;
    logic [8:0]  wrAddr;
    logic [8:0]  msgWords;
    logic [8:0]  rdAddr;
    outWord_t    push;
    logic        pushValid;
    logic        msgDone;
    logic        msgGood;
    logic        csErr;
    logic        lenErr;
    logic        fmtErr;
    logic        multiFormat;
    logic        standby;
    logic        receiving;
  } framer_t;

endpackage

// ### msg_memory.sv
// Message store with registered read data
`timescale 1ns/1ps
`include "cid_regs.svh"
module msg_memory (
  input  wire logic                        mclk,    // System clock
  input  wire logic                        nrst,    // Async reset, active low
  input  wire logic                        wrEn,    // Write strobe
  input  wire logic [`CID_MEM_AW-1:0]      wrAddr,  // Write address
  input  wire cid_pkg::memWord_t           wrData,  // Write word
  input  wire logic                        rdEn,    // Read strobe
  input  wire logic [`CID_MEM_AW-1:0]      rdAddr,  // Read address
  output cid_pkg::memWord_t                rdData   // Read word, one cycle late
);
  import cid_pkg::*;

  memWord_t mem [`CID_MEM_DEPTH];

  always_ff @(posedge mclk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rdData <= '0;
    end else if (rdEn) begin
      rdData <= mem[rdAddr];
    end
  end
endmodule

// ### two_entry_buffer.sv
// Two-entry valid/ready buffer on the decoded word path
`timescale 1ns/1ps
module two_entry_buffer (
  input  wire logic              mclk,     // System clock
  input  wire logic              nrst,     // Async reset, active low
  input  wire logic              inValid,  // Word offered
  input  wire cid_pkg::outWord_t inData,   // Offered word
  output logic                   inReady,  // Room for a word
  output logic                   outValid, // Word held at head
  output cid_pkg::outWord_t      outData,  // Head word
  input  wire logic              outReady  // Receiver takes head word
);
  import cid_pkg::*;

  bufState_t b_q;
  bufState_t b_d;

  assign inReady  = !b_q.v1;
  assign outValid = b_q.v0;
  assign outData  = b_q.e0;

  always_comb begin
    b_d = b_q;
    // Pop first so an offered word can take the head entry freed in the same cycle; a full buffer takes no word while it drains
    if (b_q.v0 && outReady) begin
      b_d.e0 = b_q.e1;
      b_d.v0 = b_q.v1;
      b_d.v1 = 1'b0;
    end
    if (inValid && !b_q.v1) begin
      if (!b_d.v0) begin
        b_d.e0 = inData;
        b_d.v0 = 1'b1;
      end else begin
        b_d.e1 = inData;
        b_d.v1 = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      b_q <= '0;
    end else begin
      b_q <= b_d;
    end
  end
endmodule

// ### caller_id_message_framer.sv
// Caller identification framer: bit deframing, message parsing, check and hand-off
`timescale 1ns/1ps
`include "cid_regs.svh"
module caller_id_message_framer #(
  parameter int unsigned BIT_CYCLES = `CID_BIT_CYCLES
) (
  input  wire logic              mclk,          // System clock, 125 MHz
  input  wire logic              nrst,          // Async reset, active low
  input  wire logic              lineBitIn,     // Demodulated line bit, pin
  input  wire logic              onHookIn,      // Handset on hook, pin
  input  wire logic              callAnsweredIn,// Call answered, pin
  input  wire logic              casAcked,      // Alert acknowledgment sent
  input  wire logic              routeToStore,  // 1 storage, 0 display
  output cid_pkg::outWord_t      wordOut,       // Decoded word
  output logic                   wordValid,     // Decoded word valid
  input  wire logic              wordReady,     // Receiver accepts word
  output logic                   msgDone,       // Message handed over, pulse
  output logic                   msgGood,       // Last message passed check
  output logic                   checksumErr,   // Checksum mismatch
  output logic                   lengthErr,     // Record overran message length
  output logic                   formatErr,     // Unknown message type
  output logic                   multiFormat,   // Last message was multi-record
  output logic                   standby,       // Parser parked after answer
  output logic                   receiving      // Message in progress
);
  import cid_pkg::*;

  localparam logic [16:0] BIT_RELOAD  = 17'(BIT_CYCLES - 1);
  localparam logic [16:0] HALF_RELOAD = 17'((BIT_CYCLES / 2) - 1);

  framer_t  f_q;
  framer_t  f_d;
  logic     memWrEn;
  memWord_t memWrData;
  logic     memRdEn;
  memWord_t memRdData;
  logic     bufInReady;

  function automatic memWord_t tagWord(input wordKind_t k, input logic [7:0] w);
    memWord_t m;
    m.kind = k;
    m.data = w;
    return m;
  endfunction

  function automatic logic [7:0] addByte(input logic [7:0] s, input logic [7:0] w);
    return 8'(s + w);
  endfunction

  always_comb begin
    logic       gotWord;
    logic [7:0] word;
    logic       leadOk;
    gotWord   = 1'b0;
    word      = 8'h00;
    leadOk    = 1'b0;
    f_d       = f_q;
    memWrEn   = 1'b0;
    memWrData = tagWord(K_DATA, 8'h00);
    memRdEn   = 1'b0;
    f_d.msgDone = 1'b0;

    // Pins pass three flops; a level counts once the last two agree
    f_d.lineSync = {f_q.lineSync[1:0], lineBitIn};
    f_d.hookSync = {f_q.hookSync[1:0], onHookIn};
    f_d.ansSync  = {f_q.ansSync[1:0], callAnsweredIn};
    if (f_q.lineSync[1] == f_q.lineSync[2]) begin
      f_d.lineLvl = f_q.lineSync[2];
    end
    if (f_q.hookSync[1] == f_q.hookSync[2]) begin
      f_d.onHookLvl = f_q.hookSync[2];
    end
    if (f_q.ansSync[1] == f_q.ansSync[2]) begin
      f_d.ansLvl = f_q.ansSync[2];
    end

    // Bit deframer, sampling mid-bit at the line rate
    case (f_q.rx)
      RX_IDLE: begin
        if (f_q.lineLvl == `CID_START_LEVEL) begin
          f_d.rx      = RX_START;
          f_d.bitCnt  = HALF_RELOAD;
          f_d.markCnt = 4'h0;
        end else if (f_q.bitCnt == 17'h0_0000) begin
          f_d.bitCnt = BIT_RELOAD;
          if (f_q.markCnt != 4'hF) begin
            f_d.markCnt = 4'(f_q.markCnt + 4'h1);
          end
        end else begin
          f_d.bitCnt = 17'(f_q.bitCnt - 17'h0_0001);
        end
      end
      RX_START: begin
        if (f_q.bitCnt == 17'h0_0000) begin
          // A glitch that is high at mid start bit is no start
          if (f_q.lineLvl != `CID_START_LEVEL) begin
            f_d.rx     = RX_IDLE;
            f_d.bitCnt = BIT_RELOAD;
          end else begin
            f_d.rx     = RX_DATA;
            f_d.bitCnt = BIT_RELOAD;
            f_d.bitIdx = 3'h0;
          end
        end else begin
          f_d.bitCnt = 17'(f_q.bitCnt - 17'h0_0001);
        end
      end
      RX_DATA: begin
        if (f_q.bitCnt == 17'h0_0000) begin
          f_d.shift  = {f_q.lineLvl, f_q.shift[7:1]};
          f_d.bitCnt = BIT_RELOAD;
          f_d.bitIdx = 3'(f_q.bitIdx + 3'h1);
          if (f_q.bitIdx == `CID_LAST_BIT_IDX) begin
            f_d.rx = RX_STOP;
          end
        end else begin
          f_d.bitCnt = 17'(f_q.bitCnt - 17'h0_0001);
        end
      end
      RX_STOP: begin
        if (f_q.bitCnt == 17'h0_0000) begin
          // Start and stop bits are dropped; a bad stop bit drops the word
          gotWord    = (f_q.lineLvl == `CID_STOP_LEVEL);
          word       = f_q.shift;
          f_d.rx     = RX_IDLE;
          f_d.bitCnt = BIT_RELOAD;
        end else begin
          f_d.bitCnt = 17'(f_q.bitCnt - 17'h0_0001);
        end
      end
      default: begin
        f_d.rx     = RX_IDLE;
        f_d.bitCnt = BIT_RELOAD;
      end
    endcase

    // Message parser
    case (f_q.ps)
      P_LEAD: begin
        if (gotWord && f_q.onHookLvl && word == `CID_SEIZE_WORD) begin
          if (f_q.seizeCnt != 4'hF) begin
            f_d.seizeCnt = 4'(f_q.seizeCnt + 4'h1);
          end
        end else if (gotWord) begin
          f_d.seizeCnt = 4'h0;
        end
        if (f_q.onHookLvl) begin
          leadOk = (f_q.seizeCnt >= `CID_SEIZE_MIN_WORDS) &&
                   (f_q.markCnt >= `CID_MARK_MIN_BITS);
        end else begin
          leadOk = casAcked && (f_q.markCnt >= `CID_MARK_MIN_BITS);
        end
        if (leadOk && f_q.rx == RX_IDLE) begin
          f_d.ps        = P_MTYPE;
          f_d.sum       = 8'h00;
          f_d.wrAddr    = 9'h000;
          f_d.csErr     = 1'b0;
          f_d.lenErr    = 1'b0;
          f_d.fmtErr    = 1'b0;
          f_d.msgGood   = 1'b0;
          f_d.receiving = 1'b1;
        end
      end
      P_MTYPE: begin
        if (gotWord) begin
          memWrEn   = 1'b1;
          memWrData = tagWord(K_MTYPE, word);
          f_d.wrAddr = 9'(f_q.wrAddr + 9'h001);
          f_d.sum    = addByte(f_q.sum, word);
          if (word == `CID_MULTI_TYPE) begin
            f_d.multi = 1'b1;
            f_d.ps    = P_MLEN;
          end else if (word == `CID_SINGLE_TYPE) begin
            f_d.multi = 1'b0;
            f_d.ps    = P_MLEN;
          end else begin
            f_d.fmtErr    = 1'b1;
            f_d.receiving = 1'b0;
            f_d.seizeCnt  = 4'h0;
            f_d.ps        = P_LEAD;
          end
        end
      end
      P_MLEN: begin
        if (gotWord) begin
          memWrEn   = 1'b1;
          memWrData = tagWord(K_MLEN, word);
          f_d.wrAddr = 9'(f_q.wrAddr + 9'h001);
          f_d.sum    = addByte(f_q.sum, word);
          f_d.remain = word;
          f_d.plen   = word;
          if (word == 8'h00) begin
            f_d.ps = P_CSUM;
          end else if (f_q.multi) begin
            f_d.ps = P_PTYPE;
          end else begin
            // Single format carries one plain data field: date, time, number
            f_d.ps = P_PDATA;
          end
        end
      end
      P_PTYPE: begin
        if (gotWord) begin
          memWrEn   = 1'b1;
          memWrData = tagWord(K_PTYPE, word);
          f_d.wrAddr = 9'(f_q.wrAddr + 9'h001);
          f_d.sum    = addByte(f_q.sum, word);
          f_d.remain = 8'(f_q.remain - 8'h01);
          if (f_q.remain < 8'h02) begin
            f_d.lenErr    = 1'b1;
            f_d.receiving = 1'b0;
            f_d.seizeCnt  = 4'h0;
            f_d.ps        = P_LEAD;
          end else begin
            f_d.ps = P_PLEN;
          end
        end
      end
      P_PLEN: begin
        if (gotWord) begin
          memWrEn   = 1'b1;
          memWrData = tagWord(K_PLEN, word);
          f_d.wrAddr = 9'(f_q.wrAddr + 9'h001);
          f_d.sum    = addByte(f_q.sum, word);
          f_d.remain = 8'(f_q.remain - 8'h01);
          f_d.plen   = word;
          if (word > 8'(f_q.remain - 8'h01)) begin
            f_d.lenErr    = 1'b1;
            f_d.receiving = 1'b0;
            f_d.seizeCnt  = 4'h0;
            f_d.ps        = P_LEAD;
          end else if (word != 8'h00) begin
            f_d.ps = P_PDATA;
          end else if (f_q.remain == 8'h01) begin
            f_d.ps = P_CSUM;
          end else begin
            f_d.ps = P_PTYPE;
          end
        end
      end
      P_PDATA: begin
        if (gotWord) begin
          memWrEn   = 1'b1;
          memWrData = tagWord(K_DATA, word);
          f_d.wrAddr = 9'(f_q.wrAddr + 9'h001);
          f_d.sum    = addByte(f_q.sum, word);
          f_d.remain = 8'(f_q.remain - 8'h01);
          f_d.plen   = 8'(f_q.plen - 8'h01);
          if (f_q.remain == 8'h01) begin
            f_d.ps = P_CSUM;
          end else if (f_q.plen == 8'h01) begin
            f_d.ps = P_PTYPE;
          end
        end
      end
      P_CSUM: begin
        if (gotWord) begin
          // Checksum is the negated byte sum, so the total must wrap to zero
          if (addByte(f_q.sum, word) == 8'h00) begin
            f_d.msgWords    = f_q.wrAddr;
            f_d.rdAddr      = 9'h000;
            f_d.multiFormat = f_q.multi;
            f_d.msgGood     = 1'b1;
            f_d.ps          = P_RDADDR;
          end else begin
            f_d.csErr     = 1'b1;
            f_d.receiving = 1'b0;
            f_d.seizeCnt  = 4'h0;
            f_d.ps        = P_LEAD;
          end
        end
      end
      P_RDADDR: begin
        memRdEn = 1'b1;
        f_d.ps  = P_RDWAIT;
      end
      P_RDWAIT: begin
        f_d.push.toStore  = routeToStore;
        f_d.push.lastWord = (f_q.rdAddr == 9'(f_q.msgWords - 9'h001));
        f_d.push.kind     = memRdData.kind;
        f_d.push.data     = memRdData.data;
        f_d.pushValid     = 1'b1;
        f_d.ps            = P_PUSH;
      end
      P_PUSH: begin
        // Held here while the receiver stalls; nothing new is parsed meanwhile
        if (bufInReady) begin
          f_d.pushValid = 1'b0;
          f_d.rdAddr    = 9'(f_q.rdAddr + 9'h001);
          if (f_q.push.lastWord) begin
            f_d.msgDone   = 1'b1;
            f_d.receiving = 1'b0;
            f_d.seizeCnt  = 4'h0;
            f_d.ps        = P_LEAD;
          end else begin
            f_d.ps = P_RDADDR;
          end
        end
      end
      P_STANDBY: begin
        if (!f_q.ansLvl) begin
          f_d.standby  = 1'b0;
          f_d.seizeCnt = 4'h0;
          f_d.ps       = P_LEAD;
        end
      end
      default: begin
        f_d.ps = P_LEAD;
      end
    endcase

    // Answering parks the parser, once a held P_PUSH word is taken, and drops any partial message
    if (f_q.ansLvl && f_q.ps != P_STANDBY && f_q.ps != P_PUSH) begin
      f_d.ps        = P_STANDBY;
      f_d.standby   = 1'b1;
      f_d.receiving = 1'b0;
      f_d.pushValid = 1'b0;
      f_d.msgDone   = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      f_q          <= '0;
      f_q.lineSync <= `CID_LINE_IDLE;
      f_q.lineLvl  <= 1'b1;
      f_q.hookSync <= `CID_PIN_RESET;
      f_q.ansSync  <= `CID_PIN_RESET;
      f_q.rx       <= RX_IDLE;
      f_q.ps       <= P_LEAD;
    end else begin
      f_q <= f_d;
    end
  end

  msg_memory u_mem (
    .mclk   (mclk),
    .nrst   (nrst),
    .wrEn   (memWrEn),
    .wrAddr (f_q.wrAddr),
    .wrData (memWrData),
    .rdEn   (memRdEn),
    .rdAddr (f_q.rdAddr),
    .rdData (memRdData)
  );

  two_entry_buffer u_buf (
    .mclk     (mclk),
    .nrst     (nrst),
    .inValid  (f_q.pushValid),
    .inData   (f_q.push),
    .inReady  (bufInReady),
    .outValid (wordValid),
    .outData  (wordOut),
    .outReady (wordReady)
  );

  assign msgDone     = f_q.msgDone;
  assign msgGood     = f_q.msgGood;
  assign checksumErr = f_q.csErr;
  assign lengthErr   = f_q.lenErr;
  assign formatErr   = f_q.fmtErr;
  assign multiFormat = f_q.multiFormat;
  assign standby     = f_q.standby;
  assign receiving   = f_q.receiving;
endmodule

// ### caller_id_message_framer_checker.sv
// Port-level assertions for the caller identification framer
`timescale 1ns/1ps
module caller_id_message_framer_checker
  import cid_pkg::*;
#(
  parameter int unsigned BIT_CYCLES = 16
) (
  input wire logic              mclk,           // System clock
  input wire logic              nrst,           // Async reset, active low
  input wire logic              callAnsweredIn, // Answer pin
  input wire cid_pkg::outWord_t wordOut,        // Decoded word
  input wire logic              wordValid,      // Word valid
  input wire logic              wordReady,      // Receiver ready
  input wire logic              msgDone,        // Message done pulse
  input wire logic              msgGood,        // Checksum good
  input wire logic              checksumErr,    // Checksum error
  input wire logic              lengthErr,      // Length error
  input wire logic              formatErr,      // Type error
  input wire logic              multiFormat,    // Multi-record message
  input wire logic              standby,        // Parked
  input wire logic              receiving       // Message in progress
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  a_hold_stall: assert property (
    wordValid && !wordReady |=> wordValid && $stable(wordOut)) else $error("stalled word lost");
  a_done_pulse: assert property (
    msgDone |=> !msgDone) else $error("done longer than one cycle");
  a_done_good: assert property (
    msgDone |-> msgGood && !checksumErr) else $error("done without good checksum");
  a_cs_silent: assert property (
    checksumErr |-> !msgGood && !msgDone) else $error("bad checksum reported good");
  a_len_abort: assert property (
    $rose(lengthErr) |-> ##[0:2] !receiving && !msgGood) else $error("overrun not abandoned");
  a_fmt_abort: assert property (
    $rose(formatErr) |-> ##[0:2] !receiving && !msgGood) else $error("bad type not abandoned");
  a_kind_legal: assert property (
    wordValid |-> wordOut.kind inside {K_MTYPE, K_MLEN, K_PTYPE, K_PLEN, K_DATA})
    else $error("illegal word kind");
  a_bad_withheld: assert property (
    wordValid |-> !(checksumErr || lengthErr || formatErr)) else $error("word of bad message");
  a_replay_pace: assert property (
    wordValid && wordReady && !wordOut.lastWord |-> ##[1:12] wordValid)
    else $error("replay stopped early");
  a_standby_quiet: assert property (
    standby && $past(standby) |-> !receiving) else $error("receiving while parked");
  a_standby_enter: assert property (
    $rose(callAnsweredIn) |-> ##[1:10] standby) else $error("answer ignored");
  c_multi: cover property (msgDone && multiFormat);
  c_single: cover property (msgDone && !multiFormat);
  c_overrun: cover property ($rose(lengthErr));
  c_park: cover property ($rose(standby));
endmodule

bind caller_id_message_framer caller_id_message_framer_checker #(.BIT_CYCLES(BIT_CYCLES)) chk (
  .mclk(mclk), .nrst(nrst), .callAnsweredIn(callAnsweredIn), .wordOut(wordOut),
  .wordValid(wordValid), .wordReady(wordReady), .msgDone(msgDone), .msgGood(msgGood),
  .checksumErr(checksumErr), .lengthErr(lengthErr), .formatErr(formatErr),
  .multiFormat(multiFormat), .standby(standby), .receiving(receiving));

// ### exchange_model.sv
// Exchange model driving the demodulated caller data bit stream
`timescale 1ns/1ps
module exchange_model #(
  parameter int unsigned BIT_CYCLES = 16
) (
  input  wire logic mclk,    // System clock
  output logic      lineBit  // Line level, 1 = mark
);
  // Mark is the resting level of the demodulated line
  initial lineBit = 1'b1;
  // Callers enter just after a clock edge, so every bit lasts whole cycles
  task automatic send_bit(input logic b);
    lineBit = b;
    repeat (BIT_CYCLES) @(posedge mclk);
    #1;
  endtask
  task automatic idle_bits(input int n);
    repeat (n) send_bit(1'b1);
  endtask
  task automatic send_word(input logic [7:0] w);
    send_bit(1'b0);
    for (int i = 0; i < 8; i++) send_bit(w[i]);
    send_bit(1'b1);
  endtask
  task automatic send_msg(input logic [7:0] m[$], input logic onHook);
    if (onHook) repeat (10) send_word(8'h55);
    idle_bits(12);
    foreach (m[i]) begin
      send_word(m[i]);
      if (i < m.size() - 1) idle_bits($urandom_range(2, 0));
    end
  endtask
endmodule

// ### caller_id_message_framer_tb.sv
// Self-checking bench for the caller identification framer
`timescale 1ns/1ps
`define CHECK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin fails++; \
  $display("wrong value t=%0h got=%h exp=%h", $time, got, exp); end end
module caller_id_message_framer_tb;
  import cid_pkg::*;
  localparam int unsigned BC = 16;
  logic mclk = 0, nrst = 0, onHookIn = 0, callAnsweredIn = 0, casAcked = 0;
  logic routeToStore = 0, wordReady = 0, stall = 0, doneSeen = 0, lineBitIn;
  logic wordValid, msgDone, msgGood, checksumErr, lengthErr, formatErr;
  logic multiFormat, standby, receiving;
  outWord_t wordOut, expW;
  outWord_t expQ[$];
  logic [7:0] m[$];
  int fails = 0, samples_checked = 0;

  caller_id_message_framer #(.BIT_CYCLES(BC)) dut (.mclk(mclk), .nrst(nrst),
    .lineBitIn(lineBitIn), .onHookIn(onHookIn), .callAnsweredIn(callAnsweredIn),
    .casAcked(casAcked), .routeToStore(routeToStore), .wordOut(wordOut),
    .wordValid(wordValid), .wordReady(wordReady), .msgDone(msgDone), .msgGood(msgGood),
    .checksumErr(checksumErr), .lengthErr(lengthErr), .formatErr(formatErr),
    .multiFormat(multiFormat), .standby(standby), .receiving(receiving));
  exchange_model #(.BIT_CYCLES(BC)) ex (.mclk(mclk), .lineBit(lineBitIn));

  always #4 mclk = ~mclk;
  always @(posedge mclk) begin
    #1;
    wordReady = !stall && ($urandom_range(3, 0) != 0);
  end
  always @(posedge mclk) begin
    if (msgDone === 1'b1) doneSeen <= 1'b1;
    if (nrst && wordValid === 1'b1 && wordReady === 1'b1) begin
      if (expQ.size() == 0) begin
        `CHECK(wordValid, 1'b0)
      end else begin
        expW = expQ.pop_front();
        `CHECK(wordOut, expW)
      end
    end
  end

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic tick;
    @(posedge mclk);
    #1;
  endtask
  function automatic logic [7:0] csum(input logic [7:0] q[$]);
    logic [7:0] s = 8'h00;
    foreach (q[i]) s += q[i];
    return 8'h00 - s;
  endfunction
  // Replay order: type, length, then records; the checksum is never handed on
  function automatic void exp_words(input logic [7:0] q[$], input logic st);
    int i = 2;
    expQ.push_back('{st, 1'b0, K_MTYPE, q[0]});
    expQ.push_back('{st, 1'b0, K_MLEN, q[1]});
    while (i < q.size()) begin
      if (q[0] == 8'h80) begin
        expQ.push_back('{st, 1'b0, K_PTYPE, q[i]});
        expQ.push_back('{st, 1'b0, K_PLEN, q[i + 1]});
        i += 2;
        repeat (q[i - 1]) expQ.push_back('{st, 1'b0, K_DATA, q[i++]});
      end else expQ.push_back('{st, 1'b0, K_DATA, q[i++]});
    end
    expQ[expQ.size() - 1].lastWord = 1'b1;
  endfunction
  function automatic void rec(input logic [7:0] t, input int n);
    m.push_back(t);
    m.push_back(8'(n));
    repeat (n) m.push_back(8'($urandom));
  endfunction
  task automatic run_msg(input logic [7:0] typ, input logic hook, input logic stallIt,
                         input logic [3:0] expF);
    int t = 0;
    m.push_front(8'(m.size()));
    m.push_front(typ);
    if (expF[3]) exp_words(m, routeToStore);
    m.push_back(csum(m) ^ {7'h00, expF[2]});
    onHookIn = hook;
    casAcked = !hook;
    stall = stallIt;
    doneSeen = 0;
    ex.send_msg(m, hook);
    // One acknowledgment covers one burst; left high, the idle line re-arms the parser
    casAcked = 0;
    if (stallIt) begin
      repeat (80) tick();
      `CHECK(wordValid, 1'b1)
      stall = 0;
    end
    while (!(doneSeen || checksumErr || lengthErr || formatErr || t > 3000)) begin
      tick();
      t++;
    end
    while (expQ.size() != 0 && t <= 3000) begin
      tick();
      t++;
    end
    if (t > 3000) begin
      fails++;
      stop_test();
    end
    `CHECK({msgGood, checksumErr, lengthErr, formatErr}, expF)
    if (expF[3]) `CHECK(multiFormat, typ == 8'h80)
    m = {};
  endtask

  initial begin
    void'($urandom(32'hcf52));
    repeat (12) @(posedge mclk);
    #1;
    nrst = 1;
    repeat (4) tick();
    rec(8'h01, 8);
    rec(8'h02, 0);
    rec(8'h07, $urandom_range(6, 1));
    run_msg(8'h80, 1'b0, 1'b1, 4'b1000);
    routeToStore = 1;
    repeat ($urandom_range(8, 1)) m.push_back(8'h30 + 8'($urandom_range(9, 0)));
    run_msg(8'h04, 1'b1, 1'b0, 4'b1000);
    rec(8'h01, 4);
    run_msg(8'h80, 1'b0, 1'b0, 4'b0100);
    m = '{8'h01, 8'h05, 8'haa};
    run_msg(8'h80, 1'b0, 1'b0, 4'b0010);
    m = '{8'h11};
    run_msg(8'h33, 1'b0, 1'b0, 4'b0001);
    casAcked = 1;
    ex.idle_bits(12);
    ex.send_word(8'h80);
    ex.send_word(8'h05);
    `CHECK(receiving, 1'b1)
    callAnsweredIn = 1;
    casAcked = 0;
    repeat (10) tick();
    `CHECK({standby, receiving}, 2'b10)
    callAnsweredIn = 0;
    repeat (10) tick();
    `CHECK(standby, 1'b0)
    routeToStore = 0;
    rec(8'h02, 0);
    rec(8'h01, $urandom_range(12, 1));
    run_msg(8'h80, 1'b1, 1'b0, 4'b1000);
    stop_test();
  end
endmodule
